// >>> rtl/psv_map.vh
`ifndef PSV_MAP_VH
`define PSV_MAP_VH

// register addresses in special-register space
`define PSV_ADDR_ACTIVE_PAGE 8'hA7
`define PSV_ADDR_PAGE_CONTROL 8'hCF
`define PSV_ADDR_STACK_VIEW 8'hD3

// page numbers
`define PSV_PAGE_0 8'h00
`define PSV_PAGE_F 8'h0F

// page control field positions
`define PSV_PGCN_EN_BIT 0
`define PSV_PGCN_IDX_LSB 4
`define PSV_PGCN_IDX_MSB 6

// reset values
`define PSV_RST_ACTIVE_PAGE 8'h00
`define PSV_RST_LEVEL_SELECT 3'h0
`define PSV_RST_AUTO_EN 1'b1
`define PSV_RST_STACK_BYTE 8'h00

// stack geometry and bit-addressable nibbles
`define PSV_STACK_DEPTH 5
`define PSV_BIT_NIBBLE_A 4'h0
`define PSV_BIT_NIBBLE_B 4'h8

`endif

// >>> rtl/psv_stack.v
`timescale 1ns/100ps
`include "psv_map.vh"

// five-deep page stack; level 0 is the active page itself
module psv_stack #(
   parameter DEPTH = `PSV_STACK_DEPTH
) (
   input wire clk,
   input wire rst_n,
   input wire page_wr,
   input wire [7:0] page_wdata,
   input wire push,
   input wire [7:0] push_page,
   input wire pop,
   input wire [2:0] level_sel,
   output wire [7:0] active_page,
   output reg [7:0] level_byte
);

   reg [7:0] lvl_q [0:DEPTH-1];
   integer k;

   ////////////////////////////////////////////////////////////////////////
   // level 0 takes software writes, interrupt loads and pops
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lvl_q[0] <= `PSV_RST_STACK_BYTE;
      end else if (push) begin
         lvl_q[0] <= push_page;
      end else if (pop) begin
         lvl_q[0] <= lvl_q[1];
      end else if (page_wr) begin
         lvl_q[0] <= page_wdata;
      end
   end

   // deeper levels shift as one; bottom refills with zero on pop
   genvar g;
   generate
      for (g = 1; g < DEPTH; g = g + 1) begin : g_lvl
         always @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               lvl_q[g] <= `PSV_RST_STACK_BYTE;
            end else if (push) begin
               lvl_q[g] <= lvl_q[g-1];
            end else if (pop) begin
               lvl_q[g] <= (g == DEPTH-1) ? `PSV_RST_STACK_BYTE : lvl_q[(g == DEPTH-1) ? g : g+1];
            end
         end
      end
   endgenerate

   assign active_page = lvl_q[0];

   // read port; codes past the bottom level return zero
   always @* begin
      level_byte = 8'h00;
      for (k = 0; k < DEPTH; k = k + 1) begin
         if (level_sel == k[2:0]) begin
            level_byte = lvl_q[k];
         end
      end
   end

endmodule

// >>> rtl/psv_top.v
`timescale 1ns/100ps
`include "psv_map.vh"

// How it works
// - stack view register is 8-bit, read-only; writes to it are ignored
// - level-select field in page control chooses which stack level is read
// - stack view decodes at 0xD3 only while the active page is F
// - bit read-modify-write allowed only at addresses with low nibble 0 or 8
// - registers decode on every page unless split; split ones decode only on pages 0 and F
// - select codes 000..100 give stack bytes one..five; 101 and 11x invalid
// - auto paging pushes page and loads flag page on entry, pops on exit
module psv_top #(
   parameter DEPTH = `PSV_STACK_DEPTH
) (
   input wire sys_clk,
   input wire rstn,
   input wire [7:0] sfr_addr,
   input wire sfr_rd,
   input wire sfr_wr,
   input wire sfr_bit_op,
   input wire [7:0] sfr_wdata,
   input wire isr_enter,
   input wire [7:0] isr_page,
   input wire isr_exit,
   output reg [7:0] sfr_rdata_q,
   output reg sfr_own_hit_q,
   output reg sfr_bank_f_q,
   output reg sfr_shared_q,
   output reg sfr_reserved_q,
   output reg bit_op_refused_q,
   output reg [7:0] active_page_q,
   output reg auto_paging_enable_q
);

   reg rst_meta_q;
   reg rst_sync_q;
   reg [2:0] stack_level_select_q;
   wire [7:0] active_page;
   wire [7:0] level_byte;
   wire on_page_f;
   wire on_page_0;
   wire acc;
   wire split;
   wire unassigned;
   wire bit_ok;
   wire wr_ok;
   wire hit_page;
   wire hit_ctl;
   wire hit_view;
   wire do_push;
   wire do_pop;
   wire page_wr;
   wire ctl_wr;
   reg [7:0] rdata_d;
   reg [2:0] stack_level_select_d;
   reg auto_paging_enable_d;
   wire sfr_own_hit_d;
   wire sfr_bank_f_d;
   wire sfr_shared_d;
   wire sfr_reserved_d;
   wire bit_op_refused_d;

   ////////////////////////////////////////////////////////////////////////
   // reset release through two flops; assertion stays asynchronous
   // the first flop may go metastable on release, so only the second is used
   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // address decode, qualified by the active page
   function is_split;
      input [7:0] a;
      begin
         // addresses with a separate register per page
         // fixed table: a variant with other split registers needs it extended
         if (a == 8'hE7 || a == 8'hD2 || a == 8'hD3 || a == 8'hD7) begin
            is_split = 1'b1;
         end else if (a == 8'hC0 || a == 8'hC1 || a == 8'hC2 || a == 8'hB9) begin
            is_split = 1'b1;
         end else if (a >= 8'hAB && a <= 8'hAE) begin
            is_split = 1'b1;
         end else if (a >= 8'h91 && a <= 8'h97) begin
            is_split = 1'b1;
         end else begin
            is_split = 1'b0;
         end
      end
   endfunction

   function is_unassigned;
      input [7:0] a;
      input pg0;
      begin
         // holes in the map; two sit only on page 0
         if (a == 8'hF5 || a == 8'hE5 || a == 8'hB0 || a == 8'hB4) begin
            is_unassigned = 1'b1;
         end else if ((a == 8'hAD || a == 8'hAE) && pg0) begin
            is_unassigned = 1'b1;
         end else begin
            is_unassigned = 1'b0;
         end
      end
   endfunction

   // the page compare uses the whole byte, so pages other than 0 and F never alias
   assign on_page_f = (active_page == `PSV_PAGE_F);
   assign on_page_0 = (active_page == `PSV_PAGE_0);
   assign acc = sfr_rd | sfr_wr;
   assign split = is_split(sfr_addr);
   // split registers exist only on pages 0 and F; other pages see a hole
   assign unassigned = is_unassigned(sfr_addr, on_page_0) | (split & ~on_page_0 & ~on_page_f);
   // a bit instruction elsewhere would disturb neighbouring bits, so it is dropped
   assign bit_ok = (sfr_addr[3:0] == `PSV_BIT_NIBBLE_A) || (sfr_addr[3:0] == `PSV_BIT_NIBBLE_B);
   // a bit instruction at a non bit-addressable address writes nothing
   assign wr_ok = sfr_wr & ~(sfr_bit_op & ~bit_ok);
   assign hit_page = (sfr_addr == `PSV_ADDR_ACTIVE_PAGE);
   assign hit_ctl = (sfr_addr == `PSV_ADDR_PAGE_CONTROL);
   assign hit_view = (sfr_addr == `PSV_ADDR_STACK_VIEW) && on_page_f;
   // writes that really land; a refused bit op never reaches a register
   assign page_wr = wr_ok & hit_page;
   assign ctl_wr = wr_ok & hit_ctl;

   ////////////////////////////////////////////////////////////////////////
   // interrupt paging; entry wins if both arrive together
   assign do_push = isr_enter & auto_paging_enable_q;
   assign do_pop = isr_exit & ~isr_enter & auto_paging_enable_q;

   // level 0 of the stack is the active page; with paging off only a software page write changes the stack

   psv_stack #(
      .DEPTH(DEPTH)
   ) u_stack (
      .clk(sys_clk),
      .rst_n(rst_sync_q),
      .page_wr(page_wr),
      .page_wdata(sfr_wdata),
      .push(do_push),
      .push_page(isr_page),
      .pop(do_pop),
      .level_sel(stack_level_select_q),
      .active_page(active_page),
      .level_byte(level_byte)
   );

   ////////////////////////////////////////////////////////////////////////
   // page control next value: select field and auto-paging enable; reserved bits drop
   // an invalid select code is kept as written so software reads back what it wrote
   always @* begin
      stack_level_select_d = stack_level_select_q;
      auto_paging_enable_d = auto_paging_enable_q;
      if (ctl_wr) begin
         stack_level_select_d = sfr_wdata[`PSV_PGCN_IDX_MSB:`PSV_PGCN_IDX_LSB];
         auto_paging_enable_d = sfr_wdata[`PSV_PGCN_EN_BIT];
      end
   end

   // page control register; the enable comes up set so paging works from reset
   // the enable gates push and pop only, never a software write of the page
   always @(posedge sys_clk or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         stack_level_select_q <= `PSV_RST_LEVEL_SELECT;
         auto_paging_enable_q <= `PSV_RST_AUTO_EN;
      end else begin
         stack_level_select_q <= stack_level_select_d;
         auto_paging_enable_q <= auto_paging_enable_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read mux; the view register has no write path at all
   // a view read off page F falls through to zero: another block owns that address on page 0, and it is a hole on other pages
   always @* begin
      rdata_d = 8'h00;
      if (hit_page) begin
         rdata_d = active_page;
      end else if (hit_ctl) begin
         rdata_d[`PSV_PGCN_IDX_MSB:`PSV_PGCN_IDX_LSB] = stack_level_select_q;
         rdata_d[`PSV_PGCN_EN_BIT] = auto_paging_enable_q;
      end else if (hit_view) begin
         rdata_d = level_byte;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // next values of the answer flags; all fall back to zero when idle
   // so that a stale flag can never be taken for a fresh answer
   assign sfr_own_hit_d = acc & (hit_page | hit_ctl | hit_view);
   // a split address on page F selects the second copy of that register
   assign sfr_bank_f_d = acc & split & on_page_f & ~unassigned;
   assign sfr_shared_d = acc & ~split & ~unassigned;
   // a hole is only flagged; this block does not stop the access itself
   assign sfr_reserved_d = acc & unassigned;
   assign bit_op_refused_d = sfr_wr & sfr_bit_op & ~bit_ok;

   ////////////////////////////////////////////////////////////////////////
   // registered answers, one cycle after the access
   // read data is zero without a read so several sources can be or-ed together
   always @(posedge sys_clk or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         sfr_rdata_q <= 8'h00;
         sfr_own_hit_q <= 1'b0;
         sfr_bank_f_q <= 1'b0;
         sfr_shared_q <= 1'b0;
         sfr_reserved_q <= 1'b0;
         bit_op_refused_q <= 1'b0;
         active_page_q <= `PSV_RST_ACTIVE_PAGE;
      end else begin
         sfr_rdata_q <= sfr_rd ? rdata_d : 8'h00;
         sfr_own_hit_q <= sfr_own_hit_d;
         sfr_bank_f_q <= sfr_bank_f_d;
         sfr_shared_q <= sfr_shared_d;
         sfr_reserved_q <= sfr_reserved_d;
         bit_op_refused_q <= bit_op_refused_d;
         active_page_q <= active_page;
      end
   end

endmodule

// >>> dv/psv_top_props.sv
`timescale 1ns/100ps
module psv_top_props (
   input logic sys_clk,
   input logic rstn,
   input logic [7:0] sfr_addr,
   input logic sfr_rd,
   input logic sfr_wr,
   input logic sfr_bit_op,
   input logic [7:0] sfr_wdata,
   input logic isr_enter,
   input logic [7:0] isr_page,
   input logic isr_exit,
   input logic [7:0] sfr_rdata_q,
   input logic sfr_own_hit_q,
   input logic sfr_bank_f_q,
   input logic sfr_shared_q,
   input logic sfr_reserved_q,
   input logic bit_op_refused_q,
   input logic [7:0] active_page_q,
   input logic auto_paging_enable_q
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   // decode flags answer exactly one cycle after the access that caused them
   own_hit_a: assert property (sfr_own_hit_q |-> $past(sfr_rd || sfr_wr) &&
      $past(sfr_addr) inside {8'hA7, 8'hCF, 8'hD3}) else $error("own hit without own access");
   idle_zero_a: assert property (!sfr_rd |=> sfr_rdata_q == 8'h00) else $error("read data not zero");
   bit_refuse_a: assert property (sfr_wr && sfr_bit_op && sfr_addr[2:0] != 3'h0
      |=> bit_op_refused_q) else $error("bit write not refused");
   bit_ok_a: assert property (sfr_wr && sfr_bit_op && sfr_addr[2:0] == 3'h0 |=> !bit_op_refused_q)
      else $error("bit write refused");
   shared_a: assert property ((sfr_rd || sfr_wr) && sfr_addr == 8'hE0 |=> sfr_shared_q && !sfr_reserved_q)
      else $error("shared address not shared");
   reserved_a: assert property ((sfr_rd || sfr_wr) && sfr_addr == 8'hF5 |=> sfr_reserved_q && !sfr_own_hit_q)
      else $error("unassigned address not flagged");
   flags_excl_a: assert property (!(sfr_shared_q && sfr_reserved_q)) else $error("shared and reserved");
   bank_excl_a: assert property (!(sfr_bank_f_q && (sfr_shared_q || sfr_reserved_q)))
      else $error("bank flag overlaps");
   // the copy of the page lags the internal page by one edge
   push_a: assert property (isr_enter && auto_paging_enable_q |=> ##1 active_page_q == $past(isr_page, 2))
      else $error("entry did not load flag page");
   enable_a: assert property (sfr_wr && !sfr_bit_op && sfr_addr == 8'hCF
      |=> auto_paging_enable_q == $past(sfr_wdata[0])) else $error("enable not written");
   cover property (sfr_own_hit_q && sfr_rdata_q != 8'h00);
   cover property (bit_op_refused_q);
   cover property (isr_exit && auto_paging_enable_q);
endmodule

// >>> dv/psv_core_model.sv
`timescale 1ns/100ps
// core side: one access at a time; released lines show the inverse so stale values cannot pass
module psv_core_model (
   input logic sys_clk,
   output logic [7:0] sfr_addr,
   output logic sfr_rd,
   output logic sfr_wr,
   output logic sfr_bit_op,
   output logic [7:0] sfr_wdata,
   output logic isr_enter,
   output logic [7:0] isr_page,
   output logic isr_exit
);
   initial begin
      {sfr_rd, sfr_wr, sfr_bit_op, isr_enter, isr_exit, sfr_addr, sfr_wdata, isr_page} = 29'h0;
   end
   // strobe held for exactly one taken edge; reserved places are only probed, never relied on
   task acc(input logic w, input logic b, input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      #1 {sfr_rd, sfr_wr, sfr_bit_op, sfr_addr, sfr_wdata} = {!w, w, b, a, d};
      @(posedge sys_clk);
      #1 {sfr_rd, sfr_wr, sfr_bit_op, sfr_addr, sfr_wdata} = {3'b000, ~a, ~d};
   endtask
   task irq(input logic enter, input logic [7:0] p);
      @(posedge sys_clk);
      #1 {isr_enter, isr_exit, isr_page} = {enter, !enter, p};
      @(posedge sys_clk);
      #1 {isr_enter, isr_exit, isr_page} = {2'b00, ~p};
   endtask
endmodule

// >>> dv/tb.sv
`timescale 1ns/100ps
`include "psv_map.vh"
`define CHK(n, e, v) begin samples_checked++; if ((v) !== (e)) begin mismatches++; \
   $display("CHECK FAILED %s expected %h seen %h", n, e, v); end end
module tb;
   logic sys_clk = 0;
   logic rstn = 0;
   logic [7:0] sfr_addr, sfr_wdata, isr_page, sfr_rdata_q, active_page_q;
   logic sfr_rd, sfr_wr, sfr_bit_op, isr_enter, isr_exit, sfr_own_hit_q, sfr_bank_f_q;
   logic sfr_shared_q, sfr_reserved_q, bit_op_refused_q, auto_paging_enable_q;
   int mismatches = 0;
   int samples_checked = 0;
   logic [7:0] exp_lvl [8] = '{8'h0F, 8'h04, 8'h03, 8'h02, 8'h01, 8'h00, 8'h00, 8'h00};
   logic [7:0] pg [4] = '{8'h02, 8'h03, 8'h04, 8'h0F};
   psv_top dut (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .sfr_addr(sfr_addr),
      .sfr_rd(sfr_rd),
      .sfr_wr(sfr_wr),
      .sfr_bit_op(sfr_bit_op),
      .sfr_wdata(sfr_wdata),
      .isr_enter(isr_enter),
      .isr_page(isr_page),
      .isr_exit(isr_exit),
      .sfr_rdata_q(sfr_rdata_q),
      .sfr_own_hit_q(sfr_own_hit_q),
      .sfr_bank_f_q(sfr_bank_f_q),
      .sfr_shared_q(sfr_shared_q),
      .sfr_reserved_q(sfr_reserved_q),
      .bit_op_refused_q(bit_op_refused_q),
      .active_page_q(active_page_q),
      .auto_paging_enable_q(auto_paging_enable_q)
   );
   psv_core_model core (
      .sys_clk(sys_clk),
      .sfr_addr(sfr_addr),
      .sfr_rd(sfr_rd),
      .sfr_wr(sfr_wr),
      .sfr_bit_op(sfr_bit_op),
      .sfr_wdata(sfr_wdata),
      .isr_enter(isr_enter),
      .isr_page(isr_page),
      .isr_exit(isr_exit)
   );
   initial forever #10 sys_clk = ~sys_clk;
   task give_verdict;
      $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // whole sequence is under a hundred cycles; this is far beyond it
   initial begin
      #100000;
      mismatches++;
      give_verdict;
   end
   initial begin
      repeat (12) @(posedge sys_clk);
      #1 rstn = 1;
      repeat (4) @(posedge sys_clk);
      #1;
      `CHK("page reset", 8'h00, active_page_q)
      `CHK("auto reset", 1'b1, auto_paging_enable_q)
      core.acc(0, 0, `PSV_ADDR_STACK_VIEW, 8'h00);
      `CHK("view page0", 9'h000, {sfr_own_hit_q, sfr_rdata_q})
      core.acc(1, 0, `PSV_ADDR_ACTIVE_PAGE, 8'h01);
      for (int i = 0; i < 4; i++) core.irq(1, pg[i]);
      // every select code, invalid ones included, after a write and four pushes
      for (int i = 0; i < 8; i++) begin
         core.acc(1, 0, `PSV_ADDR_PAGE_CONTROL, 8'(i * 16 + 1));
         core.acc(0, 0, `PSV_ADDR_STACK_VIEW, 8'h00);
         `CHK("stack level", exp_lvl[i], sfr_rdata_q)
      end
      core.acc(0, 0, `PSV_ADDR_PAGE_CONTROL, 8'h00);
      `CHK("control readback", 8'h71, sfr_rdata_q)
      core.acc(1, 0, `PSV_ADDR_PAGE_CONTROL, 8'h01);
      core.acc(1, 0, `PSV_ADDR_STACK_VIEW, 8'hAA);
      core.acc(0, 0, `PSV_ADDR_STACK_VIEW, 8'h00);
      `CHK("view ro", 9'h10F, {sfr_own_hit_q, sfr_rdata_q})
      core.acc(1, 1, `PSV_ADDR_STACK_VIEW, 8'h00);
      `CHK("bit refused", 1'b1, bit_op_refused_q)
      core.acc(1, 1, 8'hE8, 8'h00);
      `CHK("bit allowed", 1'b0, bit_op_refused_q)
      core.acc(0, 0, 8'hE0, 8'h00);
      `CHK("shared", 2'b10, {sfr_shared_q, sfr_reserved_q})
      core.acc(0, 0, 8'hF5, 8'h00);
      `CHK("reserved", 2'b01, {sfr_shared_q, sfr_reserved_q})
      core.acc(0, 0, 8'hD7, 8'h00);
      `CHK("split page F", 3'b100, {sfr_bank_f_q, sfr_shared_q, sfr_reserved_q})
      core.irq(0, 8'h00);
      @(posedge sys_clk);
      #1 `CHK("popped page", 8'h04, active_page_q)
      core.acc(0, 0, `PSV_ADDR_STACK_VIEW, 8'h00);
      `CHK("view off F", 9'h000, {sfr_own_hit_q, sfr_rdata_q})
      core.acc(0, 0, 8'hD7, 8'h00);
      `CHK("split other page", 3'b001, {sfr_bank_f_q, sfr_shared_q, sfr_reserved_q})
      core.acc(1, 0, `PSV_ADDR_PAGE_CONTROL, 8'h00);
      core.irq(1, 8'h0F);
      @(posedge sys_clk);
      #1 `CHK("no push", 8'h04, active_page_q)
      core.acc(1, 0, `PSV_ADDR_ACTIVE_PAGE, 8'h00);
      core.acc(0, 0, 8'hD7, 8'h00);
      `CHK("split page0", 3'b000, {sfr_bank_f_q, sfr_shared_q, sfr_reserved_q})
      give_verdict;
   end
endmodule
bind psv_top psv_top_props u_props (
   .sys_clk(sys_clk),
   .rstn(rstn),
   .sfr_addr(sfr_addr),
   .sfr_rd(sfr_rd),
   .sfr_wr(sfr_wr),
   .sfr_bit_op(sfr_bit_op),
   .sfr_wdata(sfr_wdata),
   .isr_enter(isr_enter),
   .isr_page(isr_page),
   .isr_exit(isr_exit),
   .sfr_rdata_q(sfr_rdata_q),
   .sfr_own_hit_q(sfr_own_hit_q),
   .sfr_bank_f_q(sfr_bank_f_q),
   .sfr_shared_q(sfr_shared_q),
   .sfr_reserved_q(sfr_reserved_q),
   .bit_op_refused_q(bit_op_refused_q),
   .active_page_q(active_page_q),
   .auto_paging_enable_q(auto_paging_enable_q)
);
